// *** src/lock_pkg.sv ***
// Package of constants and types for the lock tracker and primary bus requester.
package lock_pkg;

  // ****************************************************************
  // PCI command codes (upper nibble of the command/byte-enable lane).
  // ****************************************************************
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;

  // ****************************************************************
  // Timing counts.
  // ****************************************************************
  // Request is withdrawn for this many clocks after retry, disconnect or abort.
  localparam logic [1:0] REQ_BACKOFF_CLKS = 2'h2;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic LOCK_N_RESET = 1'b1;
  localparam logic SERR_N_RESET = 1'b1;

  // Lock tracking states, one-hot.
  typedef enum logic [5:0] {
    LK_IDLE = 6'h01,   // No lock across the bridge.
    LK_QUEUED = 6'h02, // Locked read queued, waiting for its turn.
    LK_ADDR = 6'h04,   // Locked read address phase on target bus.
    LK_TGT = 6'h08,    // Target bus locked, initiator side not yet.
    LK_BOTH = 6'h10,   // Lock held on both buses.
    LK_ABORT = 6'h20   // Abort pending to be returned on repeat.
  } lock_state_e;

  // Primary request states, one-hot.
  typedef enum logic [2:0] {
    RQ_IDLE = 3'h1,
    RQ_REQ = 3'h2,
    RQ_BACKOFF = 3'h4
  } req_state_e;

endpackage : lock_pkg

// *** src/sync3.sv ***
// Three-flop synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module sync3
  import lock_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  // ****************************************************************
  // Synchroniser chain.
  // ****************************************************************
  logic s1_r; // Metastable stage; read only by s2_r.
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // The level only moves once the second and third stages agree,
  // which filters a one-cycle glitch escaping the first stage.
  always_comb
  begin
    level_nxt = level_r;
    if (s2_r == s3_r)
    begin
      level_nxt = s3_r;
    end
  end

  // Registers only.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule : sync3
`default_nettype wire

// *** src/bridge_lock_ctrl.sv ***
// Lock tracking for locked cross-bridge transactions and primary bus request logic.
`timescale 1ns/1ps
`default_nettype none

module bridge_lock_ctrl
  import lock_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // Primary bus pins (active low, from outside the clock domain).
  input wire logic p_frame_n,
  input wire logic p_lock_n,
  input wire logic p_gnt_n,
  // Secondary bus pins.
  input wire logic s_frame_n,
  input wire logic s_irdy_n,
  input wire logic s_lock_n_in,
  output logic s_lock_n_out,
  output logic s_lock_oe,
  // Decoded primary request, one-cycle strobe from the target decoder.
  input wire logic dn_req_valid,
  input wire logic [31:0] dn_addr,
  input wire logic [3:0] dn_cmd,
  input wire logic [3:0] dn_byte_en_n,
  input wire logic dn_par,
  input wire logic dn_repeat_match,
  // Secondary master status of the locked read and of posted writes.
  input wire logic dly_head_locked,
  input wire logic s_data_done,
  input wire logic s_target_abort,
  input wire logic s_master_abort,
  input wire logic s_target_retry,
  input wire logic s_master_timeout,
  input wire logic pw_locked_done,
  input wire logic pw_abort_tabort,
  input wire logic pw_abort_mabort,
  // Configuration bits.
  input wire logic serr_enable,
  input wire logic master_abort_mode,
  input wire logic timeout_serr_enable,
  // Responses to the primary target.
  output logic dn_retry,
  output logic dn_master_abort,
  output logic dn_target_abort,
  output logic dn_locked,
  output logic no_prefetch,
  output logic s_req_allow,
  output logic [31:0] cap_addr,
  output logic [3:0] cap_cmd,
  output logic [3:0] cap_byte_en_n,
  output logic cap_par,
  output logic lock_est_secondary,
  output logic lock_est_primary,
  output logic status_tabort,
  output logic status_mabort,
  output logic system_error_n,
  // Primary arbitration.
  input wire logic up_pending,
  input wire logic up_queued,
  input wire logic p_term_backoff,
  input wire logic p_bus_idle,
  output logic p_req_n,
  output logic p_start,
  output logic p_park
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic p_frame_s;
  logic p_lock_s;
  logic p_gnt_s;
  logic s_frame_s;
  logic s_lock_s;
  logic s_irdy_s; // Secondary ready pin, filtered like the other pins.

  sync3 #(.RESET_VAL(1'b1)) u_si (.clock(clock), .rst(rst), .pin(s_irdy_n), .level(s_irdy_s));
  sync3 #(.RESET_VAL(1'b1)) u_pf (.clock(clock), .rst(rst), .pin(p_frame_n), .level(p_frame_s));
  sync3 #(.RESET_VAL(1'b1)) u_pl (.clock(clock), .rst(rst), .pin(p_lock_n), .level(p_lock_s));
  sync3 #(.RESET_VAL(1'b1)) u_pg (.clock(clock), .rst(rst), .pin(p_gnt_n), .level(p_gnt_s));
  sync3 #(.RESET_VAL(1'b1)) u_sf (.clock(clock), .rst(rst), .pin(s_frame_n), .level(s_frame_s));
  sync3 #(.RESET_VAL(1'b1)) u_sl (.clock(clock), .rst(rst), .pin(s_lock_n_in), .level(s_lock_s));

  // ****************************************************************
  // Lock tracking state.
  // ****************************************************************
  lock_state_e lk_r;
  lock_state_e lk_nxt;
  logic s_lock_drv_r; // Secondary lock driven low while set.
  logic s_lock_drv_nxt;
  logic s_lock_oe_r;
  logic s_lock_oe_nxt;
  logic abort_t_r; // Abort held for return: target abort.
  logic abort_t_nxt;
  logic abort_m_r;
  logic abort_m_nxt;
  logic serr_r;
  logic serr_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic [3:0] cmd_r;
  logic [3:0] cmd_nxt;
  logic [3:0] be_r;
  logic [3:0] be_nxt;
  logic par_r;
  logic par_nxt;
  logic is_mem_read;
  logic lock_req;

  // A locked request is a primary-side access with lock sampled low.
  // Upstream requests never come through this path, so an upstream lock
  // indication has no way to start tracking.
  assign is_mem_read = (dn_cmd == CMD_MEM_READ) || (dn_cmd == CMD_MEM_READ_MULT)
                       || (dn_cmd == CMD_MEM_READ_LINE);
  assign lock_req = dn_req_valid && !p_lock_s;

  // Next-state logic for the lock tracker.
  always_comb
  begin
    lk_nxt = lk_r;
    s_lock_drv_nxt = s_lock_drv_r;
    s_lock_oe_nxt = s_lock_oe_r;
    abort_t_nxt = abort_t_r;
    abort_m_nxt = abort_m_r;
    serr_nxt = 1'b0;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    be_nxt = be_r;
    par_nxt = par_r;
    // Posted write aborts cannot be reported back, so they go to system error.
    if (pw_abort_tabort && serr_enable)
    begin
      serr_nxt = 1'b1;
    end
    if (pw_abort_mabort && serr_enable && master_abort_mode)
    begin
      serr_nxt = 1'b1;
    end
    case (lk_r)
      LK_IDLE:
      begin
        if (lock_req && is_mem_read && s_lock_s)
        begin
          addr_nxt = dn_addr;
          cmd_nxt = dn_cmd;
          be_nxt = dn_byte_en_n;
          par_nxt = dn_par;
          abort_t_nxt = 1'b0; // Old abort status ends with a fresh lock attempt.
          abort_m_nxt = 1'b0;
          lk_nxt = LK_QUEUED;
        end
      end
      LK_QUEUED:
      begin
        // Head of queue reached and the target bus lock is free and idle.
        if (dly_head_locked && s_lock_s && s_frame_s)
        begin
          s_lock_oe_nxt = 1'b1;
          s_lock_drv_nxt = 1'b0;
          lk_nxt = LK_ADDR;
        end
      end
      LK_ADDR:
      begin
        s_lock_drv_nxt = 1'b1;
        if (s_target_abort || s_master_abort)
        begin
          abort_t_nxt = s_target_abort;
          abort_m_nxt = s_master_abort;
          s_lock_drv_nxt = 1'b0;
          s_lock_oe_nxt = 1'b0;
          lk_nxt = LK_ABORT;
        end
        else if (s_target_retry)
        begin
          s_lock_drv_nxt = 1'b0;
          s_lock_oe_nxt = 1'b0;
          lk_nxt = LK_QUEUED;
        end
        else if (s_data_done)
        begin
          lk_nxt = LK_TGT;
        end
      end
      LK_TGT:
      begin
        if (s_master_timeout)
        begin
          s_lock_drv_nxt = 1'b0;
          s_lock_oe_nxt = 1'b0;
          serr_nxt = serr_nxt || (timeout_serr_enable && serr_enable);
          lk_nxt = LK_IDLE;
        end
        else if (lock_req && dn_repeat_match)
        begin
          lk_nxt = LK_BOTH;
        end
      end
      LK_BOTH:
      begin
        // Initiator released: lock and frame both high, or locked write ended.
        if ((p_lock_s && p_frame_s) || pw_locked_done)
        begin
          s_lock_drv_nxt = 1'b0;
          s_lock_oe_nxt = 1'b0;
          lk_nxt = LK_IDLE;
        end
      end
      LK_ABORT:
      begin
        if (lock_req && dn_repeat_match)
        begin
          // The abort bits stay up as status after the repeat is answered.
          lk_nxt = LK_IDLE;
        end
      end
      default:
      begin
        lk_nxt = LK_IDLE;
        s_lock_drv_nxt = 1'b0;
        s_lock_oe_nxt = 1'b0;
      end
    endcase
  end

  // Registers of the lock tracker.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lk_r <= LK_IDLE;
      s_lock_drv_r <= 1'b0;
      s_lock_oe_r <= 1'b0;
      abort_t_r <= 1'b0;
      abort_m_r <= 1'b0;
      serr_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      cmd_r <= 4'h0;
      be_r <= 4'h0;
      par_r <= 1'b0;
    end
    else
    begin
      lk_r <= lk_nxt;
      s_lock_drv_r <= s_lock_drv_nxt;
      s_lock_oe_r <= s_lock_oe_nxt;
      abort_t_r <= abort_t_nxt;
      abort_m_r <= abort_m_nxt;
      serr_r <= serr_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      be_r <= be_nxt;
      par_r <= par_nxt;
    end
  end

  // ****************************************************************
  // Responses to the primary target logic (combinational handshakes).
  // ****************************************************************
  // An access without lock while a lock exists, or a locked read attempt while the secondary bus
  // is held by a foreign lock, is retried without forwarding.
  assign dn_retry = dn_req_valid && !dn_master_abort && !dn_target_abort
                    && ((lk_r == LK_IDLE) ? (lock_req && !s_lock_s)
                        : !((lk_r == LK_TGT || lk_r == LK_BOTH) && lock_req));
  assign dn_master_abort = dn_req_valid && (((lk_r == LK_IDLE) && lock_req && !is_mem_read)
                           || ((lk_r == LK_ABORT) && abort_m_r && lock_req));
  assign dn_target_abort = dn_req_valid && (lk_r == LK_ABORT) && abort_t_r && lock_req;
  assign dn_locked = (lk_r == LK_BOTH) || (lk_r == LK_TGT);
  assign no_prefetch = (lk_r != LK_IDLE);
  assign s_req_allow = (lk_r != LK_QUEUED) || (s_lock_s && s_frame_s && s_irdy_s);
  assign s_lock_n_out = ~s_lock_drv_r;
  assign s_lock_oe = s_lock_oe_r;
  assign cap_addr = addr_r;
  assign cap_cmd = cmd_r;
  assign cap_byte_en_n = be_r;
  assign cap_par = par_r;
  assign lock_est_secondary = (lk_r == LK_TGT) || (lk_r == LK_BOTH);
  assign lock_est_primary = (lk_r == LK_BOTH);
  assign status_tabort = abort_t_r;
  assign status_mabort = abort_m_r;
  assign system_error_n = ~serr_r;

  // ****************************************************************
  // Primary bus request and parking.
  // ****************************************************************
  req_state_e rq_r;
  req_state_e rq_nxt;
  logic [1:0] bo_cnt_r;
  logic [1:0] bo_cnt_nxt;
  logic gnt_prev_r; // Grant seen the cycle before.

  // Request only once fully queued; back off two clocks after termination.
  always_comb
  begin
    rq_nxt = rq_r;
    bo_cnt_nxt = bo_cnt_r;
    case (rq_r)
      RQ_IDLE:
      begin
        if (up_pending && up_queued)
        begin
          rq_nxt = RQ_REQ;
        end
      end
      RQ_REQ:
      begin
        if (p_term_backoff)
        begin
          bo_cnt_nxt = REQ_BACKOFF_CLKS;
          rq_nxt = RQ_BACKOFF;
        end
        else if (!up_pending)
        begin
          rq_nxt = RQ_IDLE;
        end
      end
      RQ_BACKOFF:
      begin
        bo_cnt_nxt = bo_cnt_r - 2'h1;
        if (bo_cnt_r == 2'h1)
        begin
          rq_nxt = up_pending ? RQ_REQ : RQ_IDLE;
        end
      end
      default:
      begin
        rq_nxt = RQ_IDLE;
      end
    endcase
  end

  // Registers of the requester.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rq_r <= RQ_IDLE;
      bo_cnt_r <= 2'h0;
      gnt_prev_r <= 1'b0;
    end
    else
    begin
      rq_r <= rq_nxt;
      bo_cnt_r <= bo_cnt_nxt;
      gnt_prev_r <= !p_gnt_s;
    end
  end

  assign p_req_n = (rq_r != RQ_REQ);
  // Start after grant seen with request out, with the grant held the previous cycle too
  // and the bus idle; a parked bridge does not start.
  assign p_start = (rq_r == RQ_REQ) && gnt_prev_r && !p_gnt_s && p_bus_idle;
  assign p_park = !p_gnt_s && (rq_r != RQ_REQ) && p_bus_idle;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_lock_addr_seq: assert property (@(posedge clock) disable iff (rst)
    (lk_r == LK_ADDR && !s_target_abort && !s_master_abort && !s_target_retry)
    |=> s_lock_drv_r && s_lock_oe_r)
    else $error("lock not driven after address phase");
  chk_backoff_two: assert property (@(posedge clock) disable iff (rst)
    (rq_r == RQ_REQ && p_term_backoff) |=> p_req_n [*2])
    else $error("request not withdrawn two clocks");
  chk_reset_idle: assert property (@(posedge clock) $fell(rst) |-> lk_r == LK_IDLE)
    else $error("lock state not idle after reset");
  chk_nonread_abort: assert property (@(posedge clock) disable iff (rst)
    (lk_r == LK_IDLE && lock_req && !is_mem_read) |-> dn_master_abort && !dn_retry)
    else $error("locked non-read not master aborted");
  chk_release_idle: assert property (@(posedge clock) disable iff (rst)
    (lk_r == LK_BOTH && p_lock_s && p_frame_s) |=> !s_lock_oe && lk_r == LK_IDLE)
    else $error("lock not released on initiator idle");
  chk_timeout_drop: assert property (@(posedge clock) disable iff (rst)
    (lk_r == LK_TGT && s_master_timeout) |=> !s_lock_oe)
    else $error("lock kept after master timeout");
  chk_pw_serr: assert property (@(posedge clock) disable iff (rst)
    (pw_abort_tabort && serr_enable) |=> !system_error_n)
    else $error("system error missing on write abort");
  chk_queued_retry: assert property (@(posedge clock) disable iff (rst)
    (lk_r == LK_QUEUED && dn_req_valid) |-> dn_retry)
    else $error("transaction not retried while locked read queued");
  cov_lock_both: cover property (@(posedge clock) lk_r == LK_BOTH);
  cov_lock_abort: cover property (@(posedge clock) lk_r == LK_ABORT);
  cov_backoff: cover property (@(posedge clock) rq_r == RQ_BACKOFF);

endmodule : bridge_lock_ctrl
`default_nettype wire

// *** test/lock_initiator_model.sv ***
// Primary initiator model that runs a locked sequence on the primary pins.
`timescale 1ns/1ps
`default_nettype none
module lock_initiator_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic done,
  output logic p_frame_n,
  output logic p_lock_n
);
  // High during the single address phase of the locked frame.
  logic addr_r;
  // ****************************************************************
  // Pin sequencing.
  // ****************************************************************
  // Pins move only on clock edges, so the bridge sees clean levels.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      addr_r <= 1'b0;
      p_frame_n <= 1'b1;
      p_lock_n <= 1'b1;
    end
    else if (go && p_lock_n && p_frame_n)
    begin
      // Lock stays released while the address goes out.
      addr_r <= 1'b1;
      p_frame_n <= 1'b0;
    end
    else if (addr_r)
    begin
      // Lock is taken one cycle after the address phase.
      addr_r <= 1'b0;
      p_frame_n <= 1'b1;
      p_lock_n <= 1'b0;
    end
    else if (done)
    begin
      p_lock_n <= 1'b1;
    end
  end
endmodule : lock_initiator_model
`default_nettype wire

// *** test/test_bridge_lock_ctrl.sv ***
// Self-checking bench for the lock tracker and primary requester.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_lock_ctrl
  import lock_pkg::*;
;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic clock = 1'b0;
  logic rst, p_gnt_n, s_frame_n, s_irdy_n, s_lock_n_in, dn_req_valid, dn_par;
  logic dn_repeat_match, dly_head_locked, s_master_abort, serr_enable;
  logic master_abort_mode, timeout_serr_enable, up_pending, up_queued, p_bus_idle;
  logic go, done, p_frame_n, p_lock_n;
  logic [31:0] dn_addr, cap_addr;
  logic [3:0] dn_cmd, dn_byte_en_n, cap_cmd, cap_byte_en_n;
  logic s_lock_n_out, s_lock_oe, dn_retry, dn_master_abort, dn_target_abort, dn_locked;
  logic no_prefetch, s_req_allow, cap_par, lock_est_secondary, lock_est_primary;
  logic status_tabort, status_mabort, system_error_n, p_req_n, p_start, p_park;
  // One bit per strobe input except s_master_abort and dn_req_valid, so a single task makes the other pulses.
  logic [7:0] pv;
  wire logic s_data_done, s_target_abort, s_target_retry, s_master_timeout;
  wire logic pw_locked_done, pw_abort_tabort, pw_abort_mabort, p_term_backoff;
  int error_cnt, tests_run, seed;
  // Notes of the expected answer {retry, master abort, target abort}.
  logic [2:0] expq [$];
  logic [3:0] bad [5] = '{CMD_IO_READ, CMD_IO_WRITE, CMD_MEM_WRITE, CMD_CFG_READ,
    CMD_CFG_WRITE};
  assign {p_term_backoff, pw_abort_mabort, pw_abort_tabort, pw_locked_done,
    s_master_timeout, s_target_retry, s_target_abort, s_data_done} = pv;

  always #20 clock = ~clock;

  bridge_lock_ctrl dut (.clock, .rst, .p_frame_n, .p_lock_n, .p_gnt_n, .s_frame_n,
    .s_irdy_n, .s_lock_n_in, .s_lock_n_out, .s_lock_oe, .dn_req_valid, .dn_addr,
    .dn_cmd, .dn_byte_en_n, .dn_par, .dn_repeat_match, .dly_head_locked, .s_data_done,
    .s_target_abort, .s_master_abort, .s_target_retry, .s_master_timeout,
    .pw_locked_done, .pw_abort_tabort, .pw_abort_mabort, .serr_enable,
    .master_abort_mode, .timeout_serr_enable, .dn_retry, .dn_master_abort,
    .dn_target_abort, .dn_locked, .no_prefetch, .s_req_allow, .cap_addr, .cap_cmd,
    .cap_byte_en_n, .cap_par, .lock_est_secondary, .lock_est_primary, .status_tabort,
    .status_mabort, .system_error_n, .up_pending, .up_queued, .p_term_backoff,
    .p_bus_idle, .p_req_n, .p_start, .p_park);

  lock_initiator_model initiator (.clock, .rst, .go, .done, .p_frame_n, .p_lock_n);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Output picker: 0 oe, 1 lock out, 2 est sec, 3 est pri, 4 serr, 5 req,
  // 6 start, 7 park, 8 tabort status, 9 locked, 10 no prefetch, 11 req allow.
  function automatic logic outv(input int k);
    logic [11:0] v;
    v = {s_req_allow, no_prefetch, dn_locked, status_tabort, p_park, p_start, p_req_n,
      system_error_n, lock_est_primary, lock_est_secondary, s_lock_n_out, s_lock_oe};
    return v[k];
  endfunction : outv

  // Drives always land 1 ns after the edge, away from the sampling point.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // Bounded wait: a hung design costs n cycles, not the whole run.
  task automatic wait_out(input int k, input logic v, input int n, input string m);
    int i;
    i = 0;
    while (outv(k) !== v && i < n)
    begin
      tick(1);
      i++;
    end
    chk(outv(k) === v, m);
  endtask : wait_out

  task automatic hold_out(input int k, input logic v, input int n, input string m);
    repeat (n)
    begin
      chk(outv(k) === v, m);
      tick(1);
    end
  endtask : hold_out

  task automatic pulse(input int k);
    pv[k] = 1'b1;
    tick(1);
    pv = '0;
  endtask : pulse

  // Starts (g high) or ends the initiator's locked sequence.
  task automatic ini(input logic g);
    go = g;
    done = !g;
    tick(1);
    go = 1'b0;
    done = 1'b0;
  endtask : ini

  // One decoded request with a note of the answer it should get.
  task automatic req(input logic [3:0] cmd, input logic rpt, input logic [2:0] exp);
    tick(1);
    dn_req_valid = 1'b1;
    dn_cmd = cmd;
    dn_addr = $random(seed);
    dn_byte_en_n = 4'($random(seed));
    dn_par = 1'($random(seed));
    dn_repeat_match = rpt;
    expq.push_back(exp);
    tick(1);
    dn_req_valid = 1'b0;
    dn_repeat_match = 1'b0;
  endtask : req

  task automatic endt(input string s);
    $display("test done: %s", s);
  endtask : endt

  // Queues a locked read and brings it to the target bus address phase.
  task automatic acquire;
    ini(1'b1);
    s_lock_n_in = 1'b0;
    tick(8);
    req(CMD_MEM_READ, 1'b0, 3'b100);
    s_lock_n_in = 1'b1;
    tick(8);
    req(CMD_MEM_READ, 1'b0, 3'b000);
    chk(cap_addr === dn_addr && cap_cmd === dn_cmd && cap_byte_en_n === dn_byte_en_n
      && cap_par === dn_par, "capture");
    chk(outv(10) === 1'b1, "prefetch allowed");
    s_lock_n_in = 1'b0;
    req(CMD_MEM_WRITE, 1'b0, 3'b100);
    tick(6);
    dly_head_locked = 1'b1;
    hold_out(0, 1'b0, 6, "drove lock while foreign lock held");
    chk(outv(11) === 1'b0, "bus request allowed");
    s_lock_n_in = 1'b1;
    wait_out(0, 1'b1, 10, "no lock drive");
    chk(s_lock_n_out === 1'b1, "lock active in address phase");
    tick(1);
    chk(s_lock_n_out === 1'b0, "lock not active after address");
  endtask : acquire

  // Data moves, then the repeated read takes the lock on the primary side.
  task automatic complete;
    pulse(0);
    dly_head_locked = 1'b0;
    wait_out(2, 1'b1, 4, "secondary lock missing");
    req(CMD_MEM_READ, 1'b1, 3'b000);
    wait_out(3, 1'b1, 4, "primary lock missing");
  endtask : complete

  task automatic stop_test;
    $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Answers are settled mid-cycle, well clear of the state update.
  always @(negedge clock)
    if (dn_req_valid === 1'b1)
    begin
      if (expq.size() == 0)
        chk(1'b0, "answer without note");
      else
        chk({dn_retry, dn_master_abort, dn_target_abort} === expq.pop_front(),
          "answer differs");
    end

  // Watchdog: the sequence needs about four hundred cycles.
  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    seed = 71060;
    {dn_req_valid, dn_repeat_match, dly_head_locked, s_master_abort, serr_enable} = '0;
    {master_abort_mode, timeout_serr_enable, up_pending, up_queued, go, done} = '0;
    {p_gnt_n, s_frame_n, s_irdy_n, s_lock_n_in, p_bus_idle, rst} = '1;
    {dn_addr, dn_cmd, dn_byte_en_n, dn_par, pv} = '0;
    tick(5);
    rst = 1'b0;
    tick(4);
    chk(s_lock_oe === 1'b0 && s_lock_n_out === 1'b1 && system_error_n === 1'b1
      && p_req_n === 1'b1, "reset state");
    endt("reset");
    ini(1'b1);
    tick(8);
    foreach (bad[i]) req(bad[i], 1'b0, 3'b010);
    ini(1'b0);
    tick(8);
    endt("first locked command");
    acquire();
    complete();
    chk(outv(9) === 1'b1, "forwarded transfer not locked");
    pulse(2);
    tick(2);
    chk(outv(2) === 1'b1 && outv(0) === 1'b1, "retry dropped lock");
    ini(1'b0);
    wait_out(1, 1'b1, 12, "target lock kept");
    tick(2);
    chk(outv(3) === 1'b0 && outv(2) === 1'b0, "lock state kept");
    req(CMD_MEM_WRITE, 1'b0, 3'b000);
    endt("delayed last");
    acquire();
    complete();
    pulse(4);
    wait_out(1, 1'b1, 3, "lock kept after posted write");
    ini(1'b0);
    tick(8);
    endt("posted last");
    acquire();
    pulse(1);
    dly_head_locked = 1'b0;
    tick(2);
    req(CMD_MEM_READ, 1'b1, 3'b001);
    chk(outv(8) === 1'b1 && outv(2) === 1'b0, "abort status");
    ini(1'b0);
    tick(8);
    req(CMD_MEM_WRITE, 1'b0, 3'b000);
    endt("abort");
    acquire();
    s_master_abort = 1'b1;
    tick(1);
    s_master_abort = 1'b0;
    dly_head_locked = 1'b0;
    tick(2);
    req(CMD_MEM_READ, 1'b1, 3'b010);
    chk(status_mabort === 1'b1 && status_tabort === 1'b0, "master abort status");
    ini(1'b0);
    tick(8);
    endt("master abort");
    serr_enable = 1'b1;
    timeout_serr_enable = 1'b1;
    acquire();
    pulse(0);
    tick(1);
    pulse(3);
    dly_head_locked = 1'b0;
    wait_out(4, 1'b0, 3, "timeout not reported");
    wait_out(1, 1'b1, 4, "lock kept after timeout");
    ini(1'b0);
    tick(8);
    endt("timeout");
    pulse(6);
    hold_out(4, 1'b1, 4, "master abort reported");
    pulse(5);
    wait_out(4, 1'b0, 3, "target abort not reported");
    master_abort_mode = 1'b1;
    tick(1);
    pulse(6);
    wait_out(4, 1'b0, 3, "master abort not reported");
    serr_enable = 1'b0;
    tick(1);
    pulse(5);
    hold_out(4, 1'b1, 4, "error while disabled");
    endt("system error");
    up_pending = 1'b1;
    hold_out(5, 1'b1, 3, "request before queued");
    up_queued = 1'b1;
    wait_out(5, 1'b0, 3, "no request");
    p_gnt_n = 1'b0;
    wait_out(6, 1'b1, 8, "no start");
    p_gnt_n = 1'b1;
    tick(1);
    pulse(7);
    chk(outv(5) === 1'b1, "request kept");
    tick(1);
    chk(outv(5) === 1'b1, "backoff too short");
    tick(1);
    chk(outv(5) === 1'b0, "backoff too long");
    up_pending = 1'b0;
    up_queued = 1'b0;
    wait_out(5, 1'b1, 3, "request kept idle");
    p_gnt_n = 1'b0;
    wait_out(7, 1'b1, 8, "not parked");
    p_gnt_n = 1'b1;
    endt("primary request");
    stop_test();
  end
endmodule : test_bridge_lock_ctrl
`default_nettype wire
